// ==== common/oacr_pkg.sv ====
// shared constants and types for the octal converter control register bank
package oacr_pkg;

  // serial word layout
  localparam int ADDR_W  = 8;
  localparam int DATA_W  = 16;
  localparam int WORD_W  = ADDR_W + DATA_W;
  localparam logic [4:0] WORD_LAST = 5'h17;

  // register offsets
  localparam logic [7:0] OFS_SOFT_RESET   = 8'h00;
  localparam logic [7:0] OFS_READBACK     = 8'h01;
  localparam logic [7:0] OFS_SYNC         = 8'h02;
  localparam logic [7:0] OFS_RAMP_START   = 8'h0A;
  localparam logic [7:0] OFS_POWER_REF    = 8'h0F;
  localparam logic [7:0] OFS_NOISE_CANCEL = 8'h14;
  localparam logic [7:0] OFS_FRAME_PAT    = 8'h1C;
  localparam logic [7:0] OFS_SEED_LOW     = 8'h23;
  localparam logic [7:0] OFS_SEED_HIGH    = 8'h24;

  // field positions
  localparam int BIT_SOFT_RESET    = 0;
  localparam int BIT_READBACK      = 0;
  localparam int BIT_SYNC_EN       = 13;
  localparam int BIT_FAST_WAKE     = 8;
  localparam int BIT_DEEP_SLEEP    = 9;
  localparam int BIT_SLEEP_ROLE    = 10;
  localparam int BIT_OUTSIDE_REF   = 15;
  localparam int BIT_FRAME_OVR     = 14;
  localparam int FRAME_PAT_W       = 14;
  localparam int SEED_HIGH_LSB     = 9;
  localparam int SEED_HIGH_W       = 7;
  localparam int CHAN_N            = 8;

  // reset values
  localparam logic [15:0] RST_VAL = 16'h0000;

  // receive state of the serial port
  typedef enum logic [1:0] {OACR_IDLE, OACR_SHIFT, OACR_DONE} oacr_state_t;

  // one decoded write word
  typedef struct packed {
    logic [7:0]  addr;
    logic [15:0] data;
  } oacr_word_t;

  // control fields presented to the converter core
  typedef struct packed {
    logic                   readback_mode;
    logic                   sync_enable;
    logic [15:0]            ramp_start_value;
    logic [CHAN_N-1:0]      channel_sleep_mask;
    logic                   fast_wake_sleep;
    logic                   deep_sleep;
    logic                   sleep_pin_role;
    logic                   outside_reference_enable;
    logic [CHAN_N-1:0]      lowfreq_noise_cancel_mask;
    logic                   frame_clock_override_enable;
    logic [FRAME_PAT_W-1:0] frame_clock_pattern;
    logic [15:0]            pseudo_random_start_low;
    logic [SEED_HIGH_W-1:0] pseudo_random_start_high;
    logic [CHAN_N-1:0]      input_polarity_swap_mask;
  } oacr_ctrl_t;

endpackage : oacr_pkg

// ==== verilog/oacr_serial_rx.sv ====
// serial shift-in of 24-bit address/data words
`timescale 1ns/100ps
module oacr_serial_rx (
  // clock and reset
  input  wire logic               core_clk,
  input  wire logic               rst,
  // serial pins, sampled as synchronous inputs
  input  wire logic               serial_clk,
  input  wire logic               serial_select_n,
  input  wire logic               serial_data_in,
  // decoded word
  output oacr_pkg::oacr_word_t    word,
  output logic                    word_valid,
  output logic                    addr_valid,
  output logic                    shift_edge
);
  import oacr_pkg::*;

  logic [WORD_W-1:0] shreg_reg, shreg_next;
  logic [4:0]        cnt_reg, cnt_next;
  logic              sclk_reg, sclk_next;
  logic              valid_reg, valid_next;
  logic              aval_reg, aval_next;
  logic              rise;

  assign rise = serial_clk & ~sclk_reg;

  always_comb
  begin
    shreg_next = shreg_reg;
    cnt_next   = cnt_reg;
    sclk_next  = serial_clk;
    valid_next = 1'b0;
    aval_next  = 1'b0;
    if (serial_select_n)
    begin
      cnt_next = 5'h00;
    end
    else if (rise)
    begin
      shreg_next = {shreg_reg[WORD_W-2:0], serial_data_in};
      // several words may share one select pulse
      if (cnt_reg == WORD_LAST)
      begin
        cnt_next   = 5'h00;
        valid_next = 1'b1;
      end
      else
      begin
        cnt_next = cnt_reg + 5'h01;
      end
      if (cnt_reg == 5'h07)
        aval_next = 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      shreg_reg <= '0;
      cnt_reg   <= 5'h00;
      sclk_reg  <= 1'b0;
      valid_reg <= 1'b0;
      aval_reg  <= 1'b0;
    end
    else
    begin
      shreg_reg <= shreg_next;
      cnt_reg   <= cnt_next;
      sclk_reg  <= sclk_next;
      valid_reg <= valid_next;
      aval_reg  <= aval_next;
    end
  end

  assign word       = oacr_word_t'(shreg_reg);
  assign word_valid = valid_reg;
  assign addr_valid = aval_reg;
  assign shift_edge = rise & ~serial_select_n;

endmodule : oacr_serial_rx

// ==== verilog/oacr_readback_tx.sv ====
// serial readback shifter for the readback pin
`timescale 1ns/100ps
module oacr_readback_tx (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // control
  input  wire logic        enable,
  input  wire logic        load,
  input  wire logic [15:0] load_data,
  input  wire logic        shift_edge,
  input  wire logic        serial_select_n,
  // readback pin, output enable low while driving
  output logic             readback_out,
  output logic             readback_oe_n
);
  import oacr_pkg::*;

  logic [15:0] sr_reg, sr_next;
  logic        act_reg, act_next;
  logic        out_reg, out_next;
  logic        oe_n_reg, oe_n_next;

  always_comb
  begin
    sr_next   = sr_reg;
    act_next  = act_reg;
    out_next  = out_reg;
    oe_n_next = ~enable;
    if (!enable || serial_select_n)
    begin
      act_next = 1'b0;
      out_next = 1'b0;
    end
    else if (load)
    begin
      // first data bit presented right after the address byte
      sr_next  = {load_data[14:0], 1'b0};
      out_next = load_data[15];
      act_next = 1'b1;
    end
    else if (act_reg && shift_edge)
    begin
      // changes on the same core edge that samples the rise; host samples next rise
      out_next = sr_reg[15];
      sr_next  = {sr_reg[14:0], 1'b0};
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      sr_reg   <= RST_VAL;
      act_reg  <= 1'b0;
      out_reg  <= 1'b0;
      oe_n_reg <= 1'b1;
    end
    else
    begin
      sr_reg   <= sr_next;
      act_reg  <= act_next;
      out_reg  <= out_next;
      oe_n_reg <= oe_n_next;
    end
  end

  assign readback_out  = out_reg;
  assign readback_oe_n = oe_n_reg;

endmodule : oacr_readback_tx

// ==== verilog/oacr_top.sv ====
// control register bank of an eight-channel converter, serial write/readback
`timescale 1ns/100ps
module oacr_top (
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst,
  // serial port
  input  wire logic              serial_clk,
  input  wire logic              serial_select_n,
  input  wire logic              serial_data_in,
  output logic                   serial_readback_out,
  output logic                   serial_readback_oe_n,
  // sleep pin
  input  wire logic              sleep_pin,
  // control to the converter core
  output oacr_pkg::oacr_ctrl_t   ctrl,
  output logic                   fast_wake_active,
  output logic                   deep_sleep_active,
  output logic                   frame_clock_pair
);
  import oacr_pkg::*;

  oacr_word_t  word;
  logic        word_valid;
  logic        addr_valid;
  logic        shift_edge;
  logic        rb_out;
  logic        rb_oe_n;

  oacr_ctrl_t  ctrl_reg, ctrl_next;
  logic        fast_reg, fast_next;
  logic        deep_reg, deep_next;
  logic [3:0]  fidx_reg, fidx_next;
  logic        fck_reg, fck_next;
  logic [15:0] rb_data;
  logic        rb_load;
  logic [7:0]  rb_addr;

  oacr_serial_rx u_rx (
    .core_clk        (core_clk),
    .rst             (rst),
    .serial_clk      (serial_clk),
    .serial_select_n (serial_select_n),
    .serial_data_in  (serial_data_in),
    .word            (word),
    .word_valid      (word_valid),
    .addr_valid      (addr_valid),
    .shift_edge      (shift_edge)
  );

  // readback image of one register; unused bits read zero
  function automatic logic [15:0] reg_image(input oacr_ctrl_t c, input logic [7:0] a);
    logic [15:0] v;
    v = 16'h0000;
    case (a)
      OFS_SYNC:         v[BIT_SYNC_EN] = c.sync_enable;
      OFS_RAMP_START:   v = c.ramp_start_value;
      OFS_POWER_REF:
      begin
        v[CHAN_N-1:0]      = c.channel_sleep_mask;
        v[BIT_FAST_WAKE]   = c.fast_wake_sleep;
        v[BIT_DEEP_SLEEP]  = c.deep_sleep;
        v[BIT_SLEEP_ROLE]  = c.sleep_pin_role;
        v[BIT_OUTSIDE_REF] = c.outside_reference_enable;
      end
      OFS_NOISE_CANCEL: v[CHAN_N-1:0] = c.lowfreq_noise_cancel_mask;
      OFS_FRAME_PAT:
      begin
        v[FRAME_PAT_W-1:0] = c.frame_clock_pattern;
        v[BIT_FRAME_OVR]   = c.frame_clock_override_enable;
      end
      OFS_SEED_LOW:     v = c.pseudo_random_start_low;
      OFS_SEED_HIGH:
      begin
        v[CHAN_N-1:0]                           = c.input_polarity_swap_mask;
        v[SEED_HIGH_LSB+SEED_HIGH_W-1:SEED_HIGH_LSB] = c.pseudo_random_start_high;
      end
      // register 01 and the reset register read as zero
      default:          v = 16'h0000;
    endcase
    return v;
  endfunction : reg_image

  // address byte arrives in the low bits once eight bits are in
  assign rb_addr = word.data[7:0];
  assign rb_data = reg_image(ctrl_reg, rb_addr);
  assign rb_load = addr_valid & ctrl_reg.readback_mode;

  oacr_readback_tx u_tx (
    .core_clk        (core_clk),
    .rst             (rst),
    .enable          (ctrl_reg.readback_mode),
    .load            (rb_load),
    .load_data       (rb_data),
    .shift_edge      (shift_edge),
    .serial_select_n (serial_select_n),
    .readback_out    (rb_out),
    .readback_oe_n   (rb_oe_n)
  );

  // write qualifiers of the word just committed
  logic        soft_reset_hit;
  logic        bank_write_hit;
  logic        srst_reg, srst_next;

  // while readback is active only register 01 and a soft reset can change the bank
  function automatic logic write_allowed(input logic mode, input logic [7:0] a);
    return !mode || (a == OFS_READBACK);
  endfunction : write_allowed

  // merge one accepted word; every field of the register changes at once
  function automatic oacr_ctrl_t apply_write(input oacr_ctrl_t c, input oacr_word_t w);
    oacr_ctrl_t n;
    n = c;
    case (w.addr)
      OFS_READBACK:
        n.readback_mode = w.data[BIT_READBACK];
      OFS_SYNC:
        n.sync_enable = w.data[BIT_SYNC_EN];
      OFS_RAMP_START:
        n.ramp_start_value = w.data;
      OFS_POWER_REF:
      begin
        n.channel_sleep_mask       = w.data[CHAN_N-1:0];
        n.fast_wake_sleep          = w.data[BIT_FAST_WAKE];
        n.deep_sleep               = w.data[BIT_DEEP_SLEEP];
        n.sleep_pin_role           = w.data[BIT_SLEEP_ROLE];
        n.outside_reference_enable = w.data[BIT_OUTSIDE_REF];
      end
      OFS_NOISE_CANCEL:
        n.lowfreq_noise_cancel_mask = w.data[CHAN_N-1:0];
      OFS_FRAME_PAT:
      begin
        n.frame_clock_override_enable = w.data[BIT_FRAME_OVR];
        n.frame_clock_pattern         = w.data[FRAME_PAT_W-1:0];
      end
      OFS_SEED_LOW:
        n.pseudo_random_start_low = w.data;
      OFS_SEED_HIGH:
      begin
        n.input_polarity_swap_mask = w.data[CHAN_N-1:0];
        n.pseudo_random_start_high =
          w.data[SEED_HIGH_LSB+SEED_HIGH_W-1:SEED_HIGH_LSB];
      end
      // unmapped offsets and the reset register store nothing
      default:
        n = c;
    endcase
    return n;
  endfunction : apply_write

  // the sleep pin asks for whichever depth its role selects
  function automatic logic pin_asks(input logic pin, input logic role, input logic fast);
    return pin && (role == fast);
  endfunction : pin_asks

  // frame index counts down and wraps at the frame length
  function automatic logic [3:0] frame_step(input logic [3:0] idx);
    if (idx == 4'h0)
      return 4'(FRAME_PAT_W - 1);
    return idx - 4'h1;
  endfunction : frame_step

  // normal frame is high over the first half of the count-down
  function automatic logic frame_bit(input oacr_ctrl_t c, input logic [3:0] idx);
    if (c.frame_clock_override_enable)
      return c.frame_clock_pattern[idx];
    return idx >= 4'(FRAME_PAT_W / 2);
  endfunction : frame_bit

  // soft reset is honoured even in readback mode
  assign soft_reset_hit = word_valid && (word.addr == OFS_SOFT_RESET)
    && word.data[BIT_SOFT_RESET];
  assign bank_write_hit = word_valid && write_allowed(ctrl_reg.readback_mode, word.addr);

  // soft reset bit lives for one cycle and clears itself
  always_comb
  begin
    srst_next = soft_reset_hit;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      srst_reg <= 1'b0;
    end
    else
    begin
      srst_reg <= srst_next;
    end
  end

  // register writes; the reset bit wins over any word
  always_comb
  begin
    ctrl_next = ctrl_reg;
    if (srst_reg)
    begin
      ctrl_next = '0;
    end
    else if (bank_write_hit)
    begin
      ctrl_next = apply_write(ctrl_reg, word);
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl_reg <= '0;
    end
    else
    begin
      ctrl_reg <= ctrl_next;
    end
  end

  // effective power state: register bits or the sleep pin in its role
  always_comb
  begin
    fast_next = pin_asks(sleep_pin, ctrl_reg.sleep_pin_role, 1'b1);
    fast_next = fast_next | ctrl_reg.fast_wake_sleep;
    deep_next = pin_asks(sleep_pin, ctrl_reg.sleep_pin_role, 1'b0);
    deep_next = deep_next | ctrl_reg.deep_sleep;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      fast_reg <= 1'b0;
      deep_reg <= 1'b0;
    end
    else
    begin
      fast_reg <= fast_next;
      deep_reg <= deep_next;
    end
  end

  // frame clock: half-high half-low over a 14-bit frame unless overridden
  always_comb
  begin
    fidx_next = frame_step(fidx_reg);
    fck_next  = frame_bit(ctrl_reg, fidx_reg);
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      fidx_reg <= 4'(FRAME_PAT_W - 1);
      fck_reg  <= 1'b0;
    end
    else
    begin
      fidx_reg <= fidx_next;
      fck_reg  <= fck_next;
    end
  end

  assign ctrl                 = ctrl_reg;
  assign fast_wake_active     = fast_reg;
  assign deep_sleep_active    = deep_reg;
  assign frame_clock_pair     = fck_reg;
  assign serial_readback_out  = rb_out;
  assign serial_readback_oe_n = rb_oe_n;

endmodule : oacr_top

// ==== test/oacr_top_chk.sv ====
// port assertions for the control register bank
`timescale 1ns/100ps
module oacr_top_chk (
  // clock and reset
  input wire logic                 core_clk,
  input wire logic                 rst,
  // serial port
  input wire logic                 serial_clk,
  input wire logic                 serial_select_n,
  input wire logic                 serial_data_in,
  input wire logic                 serial_readback_out,
  input wire logic                 serial_readback_oe_n,
  // sleep pin
  input wire logic                 sleep_pin,
  // core side
  input wire oacr_pkg::oacr_ctrl_t ctrl,
  input wire logic                 fast_wake_active,
  input wire logic                 deep_sleep_active,
  input wire logic                 frame_clock_pair
);
  import oacr_pkg::*;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  a_reset_clears: assert property ($past(rst) |-> ctrl == '0 && serial_readback_oe_n)
    else $error("reset left a field set");
  a_fast_wake_map: assert property (!$past(rst) |-> fast_wake_active ==
    $past(ctrl.fast_wake_sleep | (sleep_pin & ctrl.sleep_pin_role)))
    else $error("fast wake output wrong");
  a_deep_sleep_map: assert property (!$past(rst) |-> deep_sleep_active ==
    $past(ctrl.deep_sleep | (sleep_pin & !ctrl.sleep_pin_role)))
    else $error("deep sleep output wrong");
  a_oe_on_entry: assert property ($rose(ctrl.readback_mode) |=> !serial_readback_oe_n)
    else $error("readback pin not driven");
  a_oe_off_normal: assert property (!ctrl.readback_mode [*2] |-> serial_readback_oe_n)
    else $error("readback pin driven outside mode");
  a_idle_ctrl_hold: assert property (serial_select_n [*4] |-> $stable(ctrl))
    else $error("ctrl moved while deselected");
  a_write_needs_sel: assert property (!$stable(ctrl) |-> !$past(serial_select_n, 3))
    else $error("ctrl moved without a word");
  // pattern to normal hand-over skews by a cycle, hence the past guard
  a_normal_frame: assert property (disable iff (rst || ctrl.frame_clock_override_enable)
    $rose(frame_clock_pair) &&
    !ctrl.frame_clock_override_enable && !$past(ctrl.frame_clock_override_enable, 2)
    |-> frame_clock_pair [*7] ##1 !frame_clock_pair)
    else $error("normal frame shape wrong");
  c_readback: cover property ($rose(ctrl.readback_mode));
  c_fast_wake: cover property ($rose(fast_wake_active));
  c_override: cover property ($rose(ctrl.frame_clock_override_enable));
endmodule : oacr_top_chk

bind oacr_top oacr_top_chk u_chk (
  .core_clk(core_clk), .rst(rst), .serial_clk(serial_clk),
  .serial_select_n(serial_select_n), .serial_data_in(serial_data_in),
  .serial_readback_out(serial_readback_out), .serial_readback_oe_n(serial_readback_oe_n),
  .sleep_pin(sleep_pin), .ctrl(ctrl), .fast_wake_active(fast_wake_active),
  .deep_sleep_active(deep_sleep_active), .frame_clock_pair(frame_clock_pair)
);

// ==== test/oacr_host.sv ====
// behavioural serial controller driving the register bank
`timescale 1ns/100ps
module oacr_host (
  // clock
  input  wire logic core_clk,
  // serial pins
  output logic      serial_clk,
  output logic      serial_select_n,
  output logic      serial_data_in,
  input  wire logic readback_wire
);
  initial
  begin
    serial_clk = 1'b0;
    serial_select_n = 1'b1;
    serial_data_in = 1'b0;
  end
  task automatic wait_n(input int n);
    repeat (n) @(negedge core_clk);
  endtask : wait_n
  // msb first; fewer than 24 bits leaves a word the device must drop
  task automatic send(input logic [23:0] w, input int nbits, output logic [15:0] rd);
    rd = 16'h0000;
    @(negedge core_clk);
    serial_select_n = 1'b0;
    for (int i = 23; i > 23 - nbits; i--)
    begin
      serial_data_in = w[i];
      wait_n(3);
      if (i < 16)
        rd[i] = readback_wire;
      serial_clk = 1'b1;
      wait_n(1);
      // data goes stale once hold time is over
      serial_data_in = ~w[i];
      wait_n(2);
      serial_clk = 1'b0;
    end
    wait_n(3);
    serial_select_n = 1'b1;
  endtask : send
endmodule : oacr_host

// ==== test/oacr_top_tb.sv ====
// self-checking bench for the control register bank
`timescale 1ns/100ps
module oacr_top_tb;
  import oacr_pkg::*;
  logic        core_clk;
  logic        rst;
  logic        sleep_pin;
  wire         serial_clk;
  wire         serial_select_n;
  wire         serial_data_in;
  wire         rb_wire;
  logic        serial_readback_out;
  logic        serial_readback_oe_n;
  logic        fast_wake_active;
  logic        deep_sleep_active;
  logic        frame_clock_pair;
  oacr_ctrl_t  ctrl;
  oacr_ctrl_t  exp;
  logic [15:0] rd;
  logic [4:0]  ones;
  int          num_errors;
  int          num_checks;
  int          cycles;

  assign rb_wire = serial_readback_oe_n ? 1'bz : serial_readback_out;

  oacr_top u_dut (
    .core_clk(core_clk), .rst(rst), .serial_clk(serial_clk),
    .serial_select_n(serial_select_n), .serial_data_in(serial_data_in),
    .serial_readback_out(serial_readback_out), .serial_readback_oe_n(serial_readback_oe_n),
    .sleep_pin(sleep_pin), .ctrl(ctrl), .fast_wake_active(fast_wake_active),
    .deep_sleep_active(deep_sleep_active), .frame_clock_pair(frame_clock_pair)
  );
  oacr_host u_host (
    .core_clk(core_clk), .serial_clk(serial_clk), .serial_select_n(serial_select_n),
    .serial_data_in(serial_data_in), .readback_wire(rb_wire)
  );

  task automatic check(input string nm, input logic [127:0] e, input logic [127:0] s);
    num_checks++;
    if (s !== e)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, e, s);
    end
  endtask : check
  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : conclude
  // unused bits always sent as zero
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    u_host.send({a, d}, 24, rd);
    u_host.wait_n(3);
  endtask : wr
  task automatic t_reset;
    check("ctrl", '0, ctrl);
    check("oe_n", 1'b1, serial_readback_oe_n);
    $display("test reset done");
  endtask : t_reset
  task automatic t_fields;
    exp = '0;
    exp.sync_enable = 1'b1;
    exp.ramp_start_value = 16'hA5C3;
    exp.channel_sleep_mask = 8'h55;
    exp.fast_wake_sleep = 1'b1;
    exp.sleep_pin_role = 1'b1;
    exp.outside_reference_enable = 1'b1;
    exp.lowfreq_noise_cancel_mask = 8'hC3;
    exp.frame_clock_override_enable = 1'b1;
    exp.frame_clock_pattern = 14'h3F95;
    exp.pseudo_random_start_low = 16'h1234;
    exp.pseudo_random_start_high = 7'h7F;
    exp.input_polarity_swap_mask = 8'h5A;
    wr(OFS_SYNC, 16'h2000);
    wr(OFS_RAMP_START, 16'hA5C3);
    wr(OFS_POWER_REF, 16'h8555);
    wr(OFS_NOISE_CANCEL, 16'h00C3);
    wr(OFS_SEED_LOW, 16'h1234);
    wr(OFS_SEED_HIGH, 16'hFE5A);
    wr(OFS_FRAME_PAT, 16'h7F95);
    check("ctrl", exp, ctrl);
    ones = 5'h00;
    repeat (14)
    begin
      @(negedge core_clk);
      ones = ones + frame_clock_pair;
    end
    check("frame_ones", 5'h0A, ones);
    $display("test fields done");
  endtask : t_fields
  task automatic pwr(input logic [15:0] d, input logic pin, input logic f, input logic dp);
    wr(OFS_POWER_REF, d);
    sleep_pin = pin;
    u_host.wait_n(3);
    check("fast_wake", f, fast_wake_active);
    check("deep_sleep", dp, deep_sleep_active);
  endtask : pwr
  task automatic t_sleep;
    pwr(16'h0400, 1'b1, 1'b1, 1'b0);
    pwr(16'h0000, 1'b1, 1'b0, 1'b1);
    pwr(16'h0200, 1'b0, 1'b0, 1'b1);
    pwr(16'h0100, 1'b0, 1'b1, 1'b0);
    $display("test sleep done");
  endtask : t_sleep
  task automatic t_partial;
    u_host.send({OFS_RAMP_START, 16'h0000}, 12, rd);
    u_host.wait_n(3);
    check("ramp", 16'hA5C3, ctrl.ramp_start_value);
    // a leftover count would commit this word twelve bits early
    wr(OFS_SEED_LOW, 16'h4321);
    check("seed_low", 16'h4321, ctrl.pseudo_random_start_low);
    check("ramp", 16'hA5C3, ctrl.ramp_start_value);
    $display("test partial done");
  endtask : t_partial
  task automatic t_readback;
    wr(OFS_READBACK, 16'h0001);
    check("oe_n", 1'b0, serial_readback_oe_n);
    u_host.send({OFS_RAMP_START, 16'h1111}, 24, rd);
    check("read_ramp", 16'hA5C3, rd);
    check("ramp", 16'hA5C3, ctrl.ramp_start_value);
    u_host.send({OFS_READBACK, 16'h0001}, 24, rd);
    check("read_mode", 16'h0000, rd);
    wr(OFS_READBACK, 16'h0000);
    check("mode", 1'b0, ctrl.readback_mode);
    check("oe_n", 1'b1, serial_readback_oe_n);
    $display("test readback done");
  endtask : t_readback
  task automatic t_soft_reset;
    wr(OFS_SOFT_RESET, 16'h0001);
    check("ctrl", '0, ctrl);
    wr(OFS_RAMP_START, 16'h0F0F);
    check("ramp", 16'h0F0F, ctrl.ramp_start_value);
    $display("test soft reset done");
  endtask : t_soft_reset
  task automatic t_hw_reset;
    wr(OFS_NOISE_CANCEL, 16'h00FF);
    wr(OFS_POWER_REF, 16'h0300);
    check("noise", 8'hFF, ctrl.lowfreq_noise_cancel_mask);
    check("fast_wake", 1'b1, fast_wake_active);
    check("deep_sleep", 1'b1, deep_sleep_active);
    rst = 1'b1;
    u_host.wait_n(2);
    rst = 1'b0;
    @(negedge core_clk);
    check("ctrl", '0, ctrl);
    check("fast_wake", 1'b0, fast_wake_active);
    check("deep_sleep", 1'b0, deep_sleep_active);
    check("oe_n", 1'b1, serial_readback_oe_n);
    $display("test hardware reset done");
  endtask : t_hw_reset

  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // whole run is about 3100 cycles
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      conclude();
    end
  end
  initial
  begin
    rst = 1'b1;
    sleep_pin = 1'b0;
    num_errors = 0;
    num_checks = 0;
    cycles = 0;
    repeat (20) @(negedge core_clk);
    rst = 1'b0;
    @(negedge core_clk);
    t_reset();
    t_fields();
    t_sleep();
    t_partial();
    t_readback();
    t_soft_reset();
    t_hw_reset();
    conclude();
  end
endmodule : oacr_top_tb
